/* File: bmg_boot_grant.sv */
// Boot sequencer, byte DMA preset and external bus grant logic.
//
// Implementation choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "bmg_defines.svh"
module bmg_boot_grant
   import bmg_pkg::*;
(
   input  wire logic        clk,            // 10 MHz processor clock
   input  wire logic        rst_b,          // Chip reset, active low
   input  wire logic [2:0]  bootSelect,     // Mode pins C,B,A
   input  wire logic        busRequestIn_b, // External bus request, active low
   input  wire logic        extAccessBusy,  // Core external access in progress
   input  wire logic        coreWantsExt,   // Core ready with pending external access
   input  wire logic        dmaWordDone,    // One byte DMA word transferred
   input  wire logic        hostPmZeroWrite,// Host port wrote program memory 0
   output logic             busGrantOut_b,  // Bus grant, active low
   output logic             grantHangOut_b, // Grant hang, active low
   output logic             memDriveEn,     // Memory bus and strobe drivers enabled
   output logic             coreHalt,       // Execution held
   output logic             contextClear,   // Clear context, start at 0
   output logic             hostMode,       // Chip in host mode
   output logic             dmaActive,      // Byte DMA running
   output logic             dmaDoneIrq,     // Byte DMA completion pulse
   output logic [13:0]      dmaAddrOut,     // External address driven
   input  wire logic [7:0]  awaddr,         // AXI write address
   input  wire logic        awvalid,        // AXI
   output logic             awready,        // AXI
   input  wire logic [31:0] wdata,          // AXI
   input  wire logic [3:0]  wstrb,          // AXI
   input  wire logic        wvalid,         // AXI
   output logic             wready,         // AXI
   output logic [1:0]       bresp,          // AXI
   output logic             bvalid,         // AXI
   input  wire logic        bready,         // AXI
   input  wire logic [7:0]  araddr,         // AXI read address
   input  wire logic        arvalid,        // AXI
   output logic             arready,        // AXI
   output logic [31:0]      rdata,          // AXI
   output logic [1:0]       rresp,          // AXI
   output logic             rvalid,         // AXI
   input  wire logic        rready          // AXI
);
   // The core, the byte memory and the host port sit outside; this block only
   // decides when they may run, what the DMA starts from and who owns the bus.
   // The grant path has no reset on purpose, so that it answers while reset is low.

   logic         rstSeen;
   logic [2:0]   modeLatch;
   bmg_boot_type bootState;
   bmg_bus_type  busState;
   logic         xferDirection;
   logic [7:0]   extPage;
   logic [13:0]  intStartAddr;
   logic [13:0]  extStartAddr;
   logic [1:0]   wordFormat;
   logic [13:0]  xferWordCounter;
   logic         contextResetCtl;
   logic         runUntilExt;
   logic         awHeld;
   logic         wHeld;
   logic [7:0]   awAddrHeld;
   logic [31:0]  wDataHeld;
   logic         doWrite;
   logic         cntWrite;
   logic         bootHold;
   logic         bootNoLoad;
   logic         wordTaken;
   logic         grantNow;
   logic         bootHalt;
   logic         busHalt;
   logic         dmaHalt;
   logic [31:0]  readWord;
   logic [1:0]   readResp;

   // Mode pins caught on the first edge after reset release.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rstSeen <= 1'b0;
      end else begin
         rstSeen <= 1'b1;
      end
   end

   // Holding the pins only once keeps a later pin change from switching modes.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         modeLatch <= `BMG_MODE_NO_BOOT;
      end else if (!rstSeen) begin
         modeLatch <= bootSelect;
      end
   end

   // A mode with nothing to load goes straight to run.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bootState <= BMG_BOOT_IDLE;
      end else begin
         case (bootState)
            BMG_BOOT_IDLE: begin
               if (!rstSeen) begin
                  if (bootSelect == `BMG_MODE_BYTE_MEM_DMA_FULL || bootSelect == `BMG_MODE_BYTE_MEM_DMA_HOST) begin
                     bootState <= BMG_BOOT_DMA;
                  end else if (bootSelect == `BMG_MODE_HOST_PORT) begin
                     bootState <= BMG_BOOT_HOST;
                  end else begin
                     bootState <= BMG_BOOT_RUN;
                  end
               end
            end
            BMG_BOOT_DMA: begin
               if (!dmaActive) begin
                  bootState <= BMG_BOOT_RUN;
               end
            end
            BMG_BOOT_HOST: begin
               if (hostPmZeroWrite) begin
                  bootState <= BMG_BOOT_RUN;
               end
            end
            default: bootState <= BMG_BOOT_RUN;
         endcase
      end
   end

   assign hostMode = (modeLatch == `BMG_MODE_BYTE_MEM_DMA_HOST) || (modeLatch == `BMG_MODE_HOST_PORT);
   assign bootHold = (bootState != BMG_BOOT_RUN);

   // Counter writes also start a transfer when nonzero.
   assign dmaActive = (xferWordCounter != `BMG_COUNT_ZERO);

   // Modes without a byte DMA boot clear the preset count, so no transfer starts.
   assign bootNoLoad = (bootState == BMG_BOOT_IDLE) && !rstSeen
                       && (bootSelect != `BMG_MODE_BYTE_MEM_DMA_FULL)
                       && (bootSelect != `BMG_MODE_BYTE_MEM_DMA_HOST);
   assign wordTaken  = dmaActive && dmaWordDone && rstSeen;

   // Word counter and on-chip address; the reset preset serves the boot case.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         xferWordCounter <= `BMG_BOOT_WORDS;
         intStartAddr    <= `BMG_ADDR_ZERO;
      end else if (bootNoLoad) begin
         xferWordCounter <= `BMG_COUNT_ZERO;
      end else if (cntWrite) begin
         xferWordCounter <= wDataHeld[`BMG_CNT_HI:`BMG_CNT_LO];
      end else if (wordTaken) begin
         xferWordCounter <= xferWordCounter - `BMG_ADDR_STEP;
         intStartAddr    <= intStartAddr + `BMG_ADDR_STEP;
      end
   end

   // Completion pulse on the word that takes the count to zero.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         dmaDoneIrq <= 1'b0;
      end else begin
         dmaDoneIrq <= wordTaken && !bootNoLoad && !cntWrite
                       && (xferWordCounter == `BMG_LAST_WORD);
      end
   end

   // A register write wins over the boot-time clear in the same cycle.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         contextResetCtl <= `BMG_CR_RESET;
         runUntilExt     <= `BMG_GO_RESET;
      end else if (doWrite && awAddrHeld == `BMG_REG_CTRL) begin
         runUntilExt     <= wDataHeld[`BMG_CTRL_GO_BIT];
         contextResetCtl <= wDataHeld[`BMG_CTRL_CR_BIT];
      end else if (bootNoLoad) begin
         contextResetCtl <= 1'b0;
      end
   end

   // Transfer setup; software must not touch it while a transfer runs.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         xferDirection <= `BMG_DIR_RESET;
         wordFormat    <= `BMG_FMT_PM24;
         extPage       <= `BMG_PAGE_ZERO;
         extStartAddr  <= `BMG_ADDR_ZERO;
      end else if (doWrite && awAddrHeld == `BMG_REG_DMA) begin
         xferDirection <= wDataHeld[`BMG_DMA_DIR_BIT];
         wordFormat    <= wDataHeld[`BMG_DMA_FMT_HI:`BMG_DMA_FMT_LO];
         extPage       <= wDataHeld[`BMG_DMA_PAGE_HI:`BMG_DMA_PAGE_LO];
         extStartAddr  <= wDataHeld[`BMG_DMA_EXT_HI:`BMG_DMA_EXT_LO];
      end
   end

   // Host mode drives only the lowest address bit for byte DMA.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         dmaAddrOut <= `BMG_ADDR_ZERO;
      end else if (hostMode) begin
         dmaAddrOut <= extStartAddr & `BMG_ADDR_LSB_ONLY;
      end else begin
         dmaAddrOut <= extStartAddr;
      end
   end

   // Bus arbitration runs even while reset is held low.
   always_ff @(posedge clk) begin
      case (busState)
         BMG_BUS_OWN: begin
            if (!busRequestIn_b) begin
               busState <= extAccessBusy ? BMG_BUS_WAIT : BMG_BUS_GRANTED;
            end
         end
         BMG_BUS_WAIT: begin
            if (busRequestIn_b) begin
               busState <= BMG_BUS_OWN;
            end else if (!extAccessBusy) begin
               busState <= BMG_BUS_GRANTED;
            end
         end
         BMG_BUS_GRANTED: begin
            if (busRequestIn_b) begin
               busState <= BMG_BUS_OWN;
            end
         end
         default: busState <= BMG_BUS_OWN;
      endcase
   end

   assign grantNow = (busState == BMG_BUS_GRANTED) && !busRequestIn_b;

   // Grant and drivers move together, so the bus is never driven from both sides.
   always_ff @(posedge clk) begin
      busGrantOut_b <= !grantNow;
   end

   always_ff @(posedge clk) begin
      memDriveEn <= !grantNow;
   end

   // Hang only when the core really has to stop for the granted bus.
   always_ff @(posedge clk) begin
      grantHangOut_b <= !(grantNow && (coreWantsExt || !runUntilExt));
   end

   // Halt for a granted bus unless run-until-external lets the core go on.
   assign bootHalt = (bootHold && contextResetCtl) || (bootState == BMG_BOOT_HOST);
   assign busHalt  = (busState == BMG_BUS_GRANTED) && (!runUntilExt || coreWantsExt);
   assign dmaHalt  = dmaActive && contextResetCtl;
   assign coreHalt = bootHalt || busHalt || dmaHalt;
   assign contextClear = dmaActive && contextResetCtl;

   // AXI4-Lite slave; address and data taken in either order.
   assign awready = !awHeld && !bvalid;
   assign wready  = !wHeld && !bvalid;
   assign doWrite = awHeld && wHeld && !bvalid;
   assign cntWrite = doWrite && awAddrHeld == `BMG_REG_COUNT;

   // Address channel; a held address blocks the next until the response is out.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         awHeld     <= 1'b0;
         awAddrHeld <= `BMG_BYTE_ZERO;
      end else if (doWrite) begin
         awHeld <= 1'b0;
      end else if (awvalid && awready) begin
         awHeld     <= 1'b1;
         awAddrHeld <= awaddr;
      end
   end

   // Data channel, taken independently of the address.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wHeld     <= 1'b0;
         wDataHeld <= `BMG_WORD_ZERO;
      end else if (doWrite) begin
         wHeld <= 1'b0;
      end else if (wvalid && wready) begin
         wHeld     <= 1'b1;
         wDataHeld <= wdata;
      end
   end

   // The response stands until the master takes it.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bvalid <= 1'b0;
         bresp  <= `BMG_RESP_OKAY;
      end else if (doWrite) begin
         bvalid <= 1'b1;
         if (awAddrHeld == `BMG_REG_CTRL || awAddrHeld == `BMG_REG_DMA
             || awAddrHeld == `BMG_REG_COUNT) begin
            bresp <= `BMG_RESP_OKAY;
         end else begin
            bresp <= `BMG_RESP_DECERR;
         end
      end else if (bvalid && bready) begin
         bvalid <= 1'b0;
      end
   end

   assign arready = !rvalid;

   // Read word selected here so the data flop below stays simple.
   always_comb begin
      readWord = `BMG_WORD_ZERO;
      readResp = `BMG_RESP_OKAY;
      if (araddr == `BMG_REG_CTRL) begin
         readWord = {30'h0, contextResetCtl, runUntilExt};
      end else if (araddr == `BMG_REG_STATUS) begin
         readWord = {22'h0, modeLatch, hostMode, !busGrantOut_b, bootHold, coreHalt,
                     dmaActive, 2'(bootState)};
      end else if (araddr == `BMG_REG_DMA) begin
         readWord = {2'h0, extStartAddr, extPage, 5'h0, wordFormat, xferDirection};
      end else if (araddr == `BMG_REG_COUNT) begin
         readWord = {4'h0, intStartAddr, xferWordCounter};
      end else begin
         readResp = `BMG_RESP_DECERR;
      end
   end

   // Read data stands until rready, as the write response does.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rvalid <= 1'b0;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata <= `BMG_WORD_ZERO;
         rresp <= `BMG_RESP_OKAY;
      end else if (arvalid && arready) begin
         rdata <= readWord;
         rresp <= readResp;
      end
   end

endmodule : bmg_boot_grant

/* File: bmg_boot_grant_props.sv */
// Concurrent checks on the boot and bus grant ports.
`timescale 1ns/1ps
module bmg_boot_grant_props (
   input wire logic        clk,            // Clock
   input wire logic        rst_b,          // Reset, active low
   input wire logic        busRequestIn_b, // Bus request
   input wire logic        extAccessBusy,  // Access under way
   input wire logic        busGrantOut_b,  // Bus grant
   input wire logic        grantHangOut_b, // Grant hang
   input wire logic        memDriveEn,     // Drivers on
   input wire logic        coreHalt,       // Core held
   input wire logic        hostMode,       // Host mode
   input wire logic        dmaActive,      // DMA running
   input wire logic        dmaDoneIrq,     // DMA done pulse
   input wire logic [13:0] dmaAddrOut      // DMA address
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   a_grant_when_idle: assert property ((!busRequestIn_b && !extAccessBusy) [*2] |=>
      !busGrantOut_b) else $error("grant missing");
   a_float_on_grant: assert property (!busGrantOut_b |-> !memDriveEn) else $error("driving");
   a_busy_defers: assert property (extAccessBusy && busGrantOut_b |=> busGrantOut_b)
      else $error("grant too early");
   a_release_grant: assert property (busRequestIn_b [*2] |=> busGrantOut_b)
      else $error("grant kept");
   a_hang_release: assert property (busRequestIn_b [*2] |=> grantHangOut_b)
      else $error("hang kept");
   a_hang_held: assert property (!grantHangOut_b |-> !busGrantOut_b && coreHalt)
      else $error("hang without grant");
   a_irq_one_cycle: assert property (dmaDoneIrq |=> !dmaDoneIrq) else $error("irq long");
   a_irq_ends_dma: assert property (dmaDoneIrq |-> !dmaActive) else $error("dma runs on");
   a_host_addr_lsb: assert property (hostMode |-> dmaAddrOut[13:1] == 13'h0)
      else $error("upper address driven");
endmodule : bmg_boot_grant_props

/* File: bmg_boot_grant_tb_top.sv */
// Self-checking bench for the boot sequencer and bus grant block.
`timescale 1ns/1ps
module bmg_boot_grant_tb_top;
   logic        clk = 0, rst_b = 0, extAccessBusy = 0, coreWantsExt = 0, hostPmZeroWrite = 0;
   logic        want = 0, memEn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [2:0]  bootSelect = 3'h0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic [1:0]  bresp, rresp, r;
   logic [13:0] dmaAddrOut;
   logic        busRequestIn_b, dmaWordDone, busGrantOut_b, grantHangOut_b, memDriveEn, coreHalt;
   logic        contextClear, hostMode, dmaActive, dmaDoneIrq, awready, wready, bvalid;
   logic        arready, rvalid;
   int          error_cnt = 0, cmp_count = 0, irqs = 0, words, w0, i0;
   logic [2:0]  modes [8] = '{3'h0, 3'h2, 3'h4, 3'h5, 3'h1, 3'h3, 3'h6, 3'h7};
   initial forever #50 clk = ~clk;
   bmg_boot_grant dut (.clk, .rst_b, .bootSelect, .busRequestIn_b, .extAccessBusy,
      .coreWantsExt, .dmaWordDone, .hostPmZeroWrite, .busGrantOut_b, .grantHangOut_b,
      .memDriveEn, .coreHalt, .contextClear, .hostMode, .dmaActive, .dmaDoneIrq, .dmaAddrOut,
      .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid,
      .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
   bmg_far_model far (.clk, .want, .memEn, .dmaActive, .busGrantOut_b, .busRequestIn_b,
      .dmaWordDone, .words);
   always @(posedge clk) if (dmaDoneIrq === 1'b1) irqs <= irqs + 1;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic print_verdict;
      $display("Checks %0d, errors %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : print_verdict
   task automatic wait_gnt(input logic v);
      for (int n = 0; n < 20 && busGrantOut_b !== v; n++) @(posedge clk);
      @(negedge clk);
      chk(busGrantOut_b, v);
   endtask : wait_gnt
   task automatic axw(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (bvalid !== 1'b1) begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end
      r = bresp;
      bready <= 1'b0;
   endtask : axw
   task automatic axr(input logic [7:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (rvalid !== 1'b1) begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : axr
   task automatic boot(input logic [2:0] m);
      logic dma;
      dma = (m == 3'h0 || m == 3'h4);
      @(posedge clk);
      rst_b <= 1'b0;
      memEn <= 1'b0;
      bootSelect <= m;
      want <= 1'b1;
      wait_gnt(1'b0);
      @(posedge clk);
      want <= 1'b0;
      wait_gnt(1'b1);
      @(posedge clk);
      rst_b <= 1'b1;
      repeat (2) @(negedge clk);
      chk(coreHalt, dma || m == 3'h5);
      chk(dmaActive, dma);
      chk(contextClear, dma);
      if (m == 3'h2 || dma || m == 3'h5) chk(hostMode, m[2]);
      axr(8'h0c);
      chk(d[13:0], dma ? 14'h020 : 14'h000);
      axr(8'h08);
      chk(d, 32'h0);
      axr(8'h00);
      if (dma) chk(d[1], 1'b1);
      w0 = words;
      i0 = irqs;
      memEn <= 1'b1;
      hostPmZeroWrite <= (m == 3'h5);
      @(posedge clk);
      hostPmZeroWrite <= 1'b0;
      for (int n = 0; n < 400 && dmaActive !== 1'b0; n++) @(posedge clk);
      repeat (2) @(negedge clk);
      chk(words - w0, dma ? 32 : 0);
      chk(irqs - i0, dma);
      chk(coreHalt, 1'b0);
      $display("Boot mode %h done", m);
   endtask : boot
   task automatic bus_test(input logic go, input logic busy);
      @(posedge clk);
      extAccessBusy <= busy;
      want <= 1'b1;
      repeat (4) @(posedge clk);
      if (busy) chk(busGrantOut_b, 1'b1);
      extAccessBusy <= 1'b0;
      wait_gnt(1'b0);
      chk(memDriveEn, 1'b0);
      chk(coreHalt, !go);
      @(posedge clk);
      coreWantsExt <= 1'b1;
      repeat (3) @(negedge clk);
      chk(grantHangOut_b, 1'b0);
      @(posedge clk);
      want <= 1'b0;
      wait_gnt(1'b1);
      chk(grantHangOut_b, 1'b1);
      chk(memDriveEn, 1'b1);
      @(posedge clk);
      coreWantsExt <= 1'b0;
      $display("Bus test go %0d busy %0d done", go, busy);
   endtask : bus_test
   initial begin
      void'($urandom(14));
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      foreach (modes[i]) boot(modes[i]);
      bus_test(1'b0, 1'b0);
      bus_test(1'b0, 1'b1);
      axw(8'h00, 32'h1);
      chk(r, 2'h0);
      bus_test(1'b1, 1'b0);
      axr(8'h10);
      chk(r, 2'h3);
      chk(d, 32'h0);
      axw(8'h08, 32'h3fff_0000);
      @(negedge clk);
      chk(dmaAddrOut, 14'h3fff);
      print_verdict;
   end
   // A hung handshake would otherwise stall the run silently.
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      print_verdict;
   end
endmodule : bmg_boot_grant_tb_top
bind bmg_boot_grant bmg_boot_grant_props u_props (.clk, .rst_b, .busRequestIn_b, .extAccessBusy,
   .busGrantOut_b, .grantHangOut_b, .memDriveEn, .coreHalt, .hostMode, .dmaActive,
   .dmaDoneIrq, .dmaAddrOut);

/* File: bmg_defines.svh */
// Constants for the boot mode sequencer and bus grant block.
// How it works
// - Mode 000: byte DMA boot, hold, full memory.
// - Mode 010: no boot, run from zero.
// - Mode 100: byte DMA boot, host mode.
// - Mode 101: host port boot, wait for write.
// - Byte DMA boot starts at reset release.
// - Reset clears direction, page, addresses, format.
// - Reset loads word counter with thirty-two.
// - Reset sets context reset control bit.
// - Idle bus: halt next cycle, grant and float the cycle after.
// - Run-until-external mode keeps executing after grant.
// - Busy bus: grant after access completes.
// - Grant allowed between two accesses.
// - Request drop: release grant, resume.
// - Requests honoured always, even in reset.
// - Grant-hang flags blocked ready execution.
// - Mode pins sampled at reset release.
// - Context reset: stop, clear, restart at zero.
// - Counter decrements; zero ends and interrupts.
`ifndef BMG_DEFINES_SVH
`define BMG_DEFINES_SVH
`define BMG_MODE_BYTE_MEM_DMA_FULL 3'h0
`define BMG_MODE_NO_BOOT   3'h2
`define BMG_MODE_BYTE_MEM_DMA_HOST 3'h4
`define BMG_MODE_HOST_PORT 3'h5
`define BMG_BOOT_WORDS     14'h020
`define BMG_FMT_PM24       2'h0
`define BMG_ADDR_LSB_ONLY  14'h0001
// AXI4-Lite byte addresses.
`define BMG_REG_CTRL       8'h00
`define BMG_REG_STATUS     8'h04
`define BMG_REG_DMA        8'h08
`define BMG_REG_COUNT      8'h0c
`define BMG_CTRL_GO_BIT    0
`define BMG_CTRL_CR_BIT    1
`define BMG_RESP_OKAY      2'h0
`define BMG_RESP_DECERR    2'h3
// Reset values and register field positions.
`define BMG_ADDR_ZERO      14'h0000
`define BMG_COUNT_ZERO     14'h0000
`define BMG_ADDR_STEP      14'h0001
`define BMG_LAST_WORD      14'h0001
`define BMG_PAGE_ZERO      8'h00
`define BMG_BYTE_ZERO      8'h00
`define BMG_WORD_ZERO      32'h0000_0000
`define BMG_DIR_RESET      1'b0
`define BMG_CR_RESET       1'b1
`define BMG_GO_RESET       1'b0
`define BMG_DMA_DIR_BIT    0
`define BMG_DMA_FMT_HI     2
`define BMG_DMA_FMT_LO     1
`define BMG_DMA_PAGE_HI    15
`define BMG_DMA_PAGE_LO    8
`define BMG_DMA_EXT_HI     29
`define BMG_DMA_EXT_LO     16
`define BMG_CNT_HI         13
`define BMG_CNT_LO         0
`endif

/* File: bmg_far_model.sv */
// Far side: external bus requester and byte-wide boot memory.
`timescale 1ns/1ps
module bmg_far_model (
   input wire logic clk,            // Clock
   input wire logic want,           // Bench needs the bus
   input wire logic memEn,          // Memory may answer
   input wire logic dmaActive,      // Device DMA running
   input wire logic busGrantOut_b,  // Device grant
   output logic     busRequestIn_b, // Request to device
   output logic     dmaWordDone,    // One word delivered
   output int       words           // Words delivered
);
   int gap = 0;
   initial busRequestIn_b = 1'b1;
   initial dmaWordDone = 1'b0;
   initial words = 0;
   always @(posedge clk) busRequestIn_b <= !want;
   always @(posedge clk) begin
      dmaWordDone <= 1'b0;
      if (gap > 0) gap <= gap - 1;
      else if (memEn && dmaActive && busGrantOut_b && !dmaWordDone) begin
         dmaWordDone <= 1'b1;
         words <= words + 1;
         gap <= $urandom_range(4);
      end
   end
endmodule : bmg_far_model

/* File: bmg_pkg.sv */
// Types shared by the boot and bus grant logic.
package bmg_pkg;
   typedef enum logic [2:0] {BMG_BOOT_IDLE, BMG_BOOT_DMA, BMG_BOOT_HOST, BMG_BOOT_RUN}
      bmg_boot_type;
   typedef enum logic [1:0] {BMG_BUS_OWN, BMG_BUS_WAIT, BMG_BUS_GRANTED} bmg_bus_type;
endpackage : bmg_pkg
